// ### verilog/uif_irq_top.sv
// usb device interrupt flags, enables and apb register slave
`timescale 1ns/1ns
`default_nettype none

module uif_irq_top
   import uif_pkg::*;
#(
   parameter int EP_NUM = UIF_EP_NUM
) (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    nrst,
   // apb slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [31:0]             paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   // event pulses from the usb core
   input  wire logic [EP_NUM-1:0]       endpointEvt,
   input  wire logic                    suspendEvt,
   input  wire logic                    resumeEvt,
   input  wire logic                    busResetEvt,
   input  wire logic                    disconnectDoneEvt,
   // views for the usb core and the cpu
   output logic      [UIF_DATA_W-1:0]   usbIrqEnable,
   output logic      [UIF_DATA_W-1:0]   usbIrqStatus,
   output logic                         irqReq
);
   import uif_pkg::*;

   ///////////////////////////////////////////////////////////////////////
   // declarations

   uif_apb_st_t              apbSt_q;
   uif_apb_st_t              apbSt_d;

   logic [UIF_DATA_W-1:0]    enable_q;     // usb_irq_enable
   logic [UIF_DATA_W-1:0]    enable_d;
   logic [UIF_DATA_W-1:0]    status_q;     // registered copy of the flags
   logic [31:0]              rdata_q;
   logic [31:0]              rdata_d;
   logic                     slvErr_q;
   logic                     slvErr_d;
   logic                     ready_q;
   logic                     irq_q;
   logic                     irq_d;

   logic [UIF_DATA_W-1:0]    eventVec;
   logic [UIF_DATA_W-1:0]    clearVec;
   logic [UIF_DATA_W-1:0]    pendingVec;
   logic [31:0]              byteMask;
   logic [31:0]              readMux;

   logic                     apbSetup;
   logic                     apbDone;
   logic                     wrDone;
   logic                     hitStatus;
   logic                     hitEnable;
   logic                     hitPending;
   logic                     hitOverrun;
   logic                     hitAny;

   uif_flag_if #(.W(UIF_DATA_W)) flagBus ();

   ///////////////////////////////////////////////////////////////////////
   // gather the core events into status bit positions

   // endpoint sources fill the low bits; reserved positions stay zero
   genvar e;
   generate
      for (e = 0; e < UIF_DATA_W; e++) begin : g_evt
         if (e >= UIF_BIT_EP0 && e < UIF_BIT_EP0 + EP_NUM) begin : g_ep
            assign eventVec[e] = endpointEvt[e - UIF_BIT_EP0];
         end else if (e == UIF_BIT_SUSPEND) begin : g_sus
            assign eventVec[e] = suspendEvt;
         end else if (e == UIF_BIT_RESUME) begin : g_res
            assign eventVec[e] = resumeEvt;
         end else if (e == UIF_BIT_BUSRESET) begin : g_rst
            assign eventVec[e] = busResetEvt;
         end else if (e == UIF_BIT_DISCONNECT) begin : g_dis
            assign eventVec[e] = disconnectDoneEvt;
         end else begin : g_none
            assign eventVec[e] = 1'b0;
         end
      end
   endgenerate

   ///////////////////////////////////////////////////////////////////////
   // sticky flag bank; events set, software write-one clears

   assign flagBus.evtPulse = eventVec & UIF_STATUS_MASK;
   assign flagBus.clrPulse = clearVec;

   uif_flag_bank #(
      .IMPL (UIF_STATUS_MASK)
   ) u_flags (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .fb      (flagBus.bank)
   );

   ///////////////////////////////////////////////////////////////////////
   // apb address decode and phase qualifiers

   // a full 32-bit compare keeps aliases off the map
   assign hitStatus  = (paddr == UIF_ADDR_STATUS);
   assign hitEnable  = (paddr == UIF_ADDR_ENABLE);
   assign hitPending = (paddr == UIF_ADDR_PENDING);
   assign hitOverrun = (paddr == UIF_ADDR_OVERRUN);
   assign hitAny     = hitStatus | hitEnable | hitPending | hitOverrun;

   // first access cycle is spent fetching; the next one completes
   assign apbSetup = psel & penable & (apbSt_q == UIF_ST_IDLE);
   assign apbDone  = psel & penable & (apbSt_q == UIF_ST_ANSWER);
   assign wrDone   = apbDone & pwrite & hitAny;

   // byte lanes widened to a bit mask
   assign byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                      {8{pstrb[1]}}, {8{pstrb[0]}}};

   ///////////////////////////////////////////////////////////////////////
   // register write effects

   // enable: cpu read/write, reserved bits forced to zero
   assign enable_d = (wrDone && hitEnable) ?
                     (((pwdata & byteMask) | (enable_q & ~byteMask))
                      & UIF_ENABLE_MASK) :
                     enable_q;

   // status and overrun: write one clears the bits under the byte lanes
   assign clearVec = (wrDone && (hitStatus || hitOverrun)) ?
                     (pwdata & byteMask & UIF_STATUS_MASK) :
                     {UIF_DATA_W{1'b0}};

   ///////////////////////////////////////////////////////////////////////
   // interrupt gating

   // a cleared enable bit blocks its flag, a set one passes it
   assign pendingVec = flagBus.flags & enable_q;
   assign irq_d      = |pendingVec;

   ///////////////////////////////////////////////////////////////////////
   // read data selection

   assign readMux = hitStatus  ? (flagBus.flags & UIF_STATUS_MASK) :
                    hitEnable  ? enable_q :
                    hitPending ? pendingVec :
                    hitOverrun ? (flagBus.overrun & UIF_STATUS_MASK) :
                                 UIF_READ_IDLE;

   // answer contents are captured in the first access cycle
   assign rdata_d  = (apbSetup && !pwrite) ? readMux :
                     apbDone               ? UIF_READ_IDLE :
                                             rdata_q;
   assign slvErr_d = apbSetup ? ~hitAny :
                     apbDone  ? 1'b0 :
                                slvErr_q;

   ///////////////////////////////////////////////////////////////////////
   // apb phase state

   // next phase: answer one cycle after the access begins
   always_comb begin
      apbSt_d = apbSt_q;
      case (apbSt_q)
         UIF_ST_IDLE: begin
            if (apbSetup) begin
               apbSt_d = UIF_ST_ANSWER;
            end
         end
         UIF_ST_ANSWER: begin
            apbSt_d = UIF_ST_IDLE;
         end
         default: begin
            apbSt_d = UIF_ST_IDLE;
         end
      endcase
   end

   // phase register and ready strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         apbSt_q <= UIF_ST_IDLE;
         ready_q <= 1'b0;
      end else begin
         apbSt_q <= apbSt_d;
         ready_q <= (apbSt_d == UIF_ST_ANSWER);
      end
   end

   // answer data and error
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q  <= UIF_READ_IDLE;
         slvErr_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         slvErr_q <= slvErr_d;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // enable register, status copy and request output

   // all sources disabled out of reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         enable_q <= UIF_ENABLE_RST;
      end else begin
         enable_q <= enable_d;
      end
   end

   // registered views for the core and the single request line
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= UIF_STATUS_RST;
         irq_q    <= 1'b0;
      end else begin
         status_q <= flagBus.flags;
         irq_q    <= irq_d;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // outputs, each straight from a flip-flop

   assign prdata       = rdata_q;
   assign pready       = ready_q;
   assign pslverr      = slvErr_q;
   assign usbIrqEnable = enable_q;
   assign usbIrqStatus = status_q;
   assign irqReq       = irq_q;

endmodule
`default_nettype wire

// ### verilog/uif_pkg.sv
// package of register map, field layout and reset values for the irq flags
package uif_pkg;

   // system addresses of the word registers
   localparam logic [31:0] UIF_ADDR_STATUS  = 32'hF00E_0008;
   localparam logic [31:0] UIF_ADDR_ENABLE  = 32'hF00E_000C;
   localparam logic [31:0] UIF_ADDR_PENDING = 32'hF00E_0010;
   localparam logic [31:0] UIF_ADDR_OVERRUN = 32'hF00E_0014;

   // register width and number of endpoint sources
   localparam int UIF_DATA_W = 32;
   localparam int UIF_EP_NUM = 5;

   // field positions shared by status and enable
   localparam int UIF_BIT_EP0       = 0;
   localparam int UIF_BIT_SUSPEND   = 8;
   localparam int UIF_BIT_RESUME    = 9;
   localparam int UIF_BIT_BUSRESET  = 10;
   localparam int UIF_BIT_DISCONNECT = 11;

   // implemented bits; all others are reserved and read zero
   localparam logic [31:0] UIF_STATUS_MASK = 32'h0000_0F1F;
   localparam logic [31:0] UIF_ENABLE_MASK = 32'h0000_0D1F;

   // reset values
   localparam logic [31:0] UIF_ENABLE_RST  = 32'h0000_0000;
   localparam logic [31:0] UIF_STATUS_RST  = 32'h0000_0000;
   localparam logic [31:0] UIF_READ_IDLE   = 32'h0000_0000;

   // apb slave phase; gray coded along idle -> answer -> idle
   typedef enum logic [1:0] {
      UIF_ST_IDLE   = 2'b00,
      UIF_ST_ANSWER = 2'b01
   } uif_apb_st_t;

endpackage

// ### verilog/uif_flag_if.sv
// interface carrying events, clears and flag state to the flag bank
`timescale 1ns/1ns
`default_nettype none
interface uif_flag_if #(
   parameter int W = 32
);
   logic [W-1:0] evtPulse;   // hardware set, one cycle per event
   logic [W-1:0] clrPulse;   // software clear, one cycle
   logic [W-1:0] flags;      // sticky flags
   logic [W-1:0] overrun;    // event seen while flag already set

   // the bank owns the sticky state
   modport bank (
      input  evtPulse,
      input  clrPulse,
      output flags,
      output overrun
   );

   // the controller feeds events and reads state
   modport ctrl (
      output evtPulse,
      output clrPulse,
      input  flags,
      input  overrun
   );
endinterface
`default_nettype wire

// ### verilog/uif_flag_bank.sv
// sticky flag bank: one set-dominant flag and overrun bit per implemented position
`timescale 1ns/1ns
`default_nettype none
module uif_flag_bank
   import uif_pkg::*;
#(
   parameter logic [31:0] IMPL = UIF_STATUS_MASK
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic nrst,
   // flag traffic
   uif_flag_if.bank  fb
);
   import uif_pkg::*;

   ///////////////////////////////////////////////////////////////////////
   // one cell per bit; reserved positions are constant zero
   genvar i;
   generate
      for (i = 0; i < UIF_DATA_W; i++) begin : g_bit
         if (IMPL[i]) begin : g_impl
            logic flag_q;
            logic flag_d;
            logic ovr_q;
            logic ovr_d;
            // a set in the same cycle as a clear wins for the flag; for the overrun bit the clear wins
            assign flag_d = fb.evtPulse[i] |
                            (flag_q & ~fb.clrPulse[i]);
            assign ovr_d  = (fb.evtPulse[i] & flag_q & ~fb.clrPulse[i]) |
                            (ovr_q & ~fb.clrPulse[i]);
            // sticky state
            always_ff @(posedge sys_clk or negedge nrst) begin
               if (!nrst) begin
                  flag_q <= 1'b0;
                  ovr_q  <= 1'b0;
               end else begin
                  flag_q <= flag_d;
                  ovr_q  <= ovr_d;
               end
            end
            assign fb.flags[i]   = flag_q;
            assign fb.overrun[i] = ovr_q;
         end else begin : g_rsv
            assign fb.flags[i]   = 1'b0;
            assign fb.overrun[i] = 1'b0;
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ### tb/uif_irq_top_monitor.sv
// port-level checker of the usb irq flag block
`timescale 1ns/1ns
`default_nettype none
module uif_irq_top_monitor
   import uif_pkg::*;
#(
   parameter int EP_NUM = UIF_EP_NUM
) (
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              nrst,
   // apb
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic              pready,
   // events and views
   input wire logic [EP_NUM-1:0] endpointEvt,
   input wire logic              suspendEvt,
   input wire logic              resumeEvt,
   input wire logic              busResetEvt,
   input wire logic              disconnectDoneEvt,
   input wire logic [31:0]       usbIrqEnable,
   input wire logic [31:0]       usbIrqStatus,
   input wire logic              irqReq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////
   // request follows flags and the enables of the cycle before
   a_irq_follows: assert property (
      irqReq == |(usbIrqStatus & $past(usbIrqEnable)))
      else $error("irq request disagrees with flags and enables");
   a_enable_rsvd: assert property (
      (usbIrqEnable & ~UIF_ENABLE_MASK) == 32'h0000_0000)
      else $error("reserved enable bit set");
   a_status_rsvd: assert property (
      (usbIrqStatus & ~UIF_STATUS_MASK) == 32'h0000_0000)
      else $error("reserved status bit set");
   a_suspend_set: assert property (
      suspendEvt |-> ##2 usbIrqStatus[UIF_BIT_SUSPEND])
      else $error("suspend flag missing");
   a_resume_set: assert property (
      resumeEvt |-> ##2 usbIrqStatus[UIF_BIT_RESUME])
      else $error("resume flag missing");
   a_busreset_set: assert property (
      busResetEvt |-> ##2 usbIrqStatus[UIF_BIT_BUSRESET])
      else $error("bus reset flag missing");
   a_disc_set: assert property (
      disconnectDoneEvt |-> ##2 usbIrqStatus[UIF_BIT_DISCONNECT])
      else $error("disconnect flag missing");
   a_endpoint_set: assert property (
      |endpointEvt |-> ##2 &(usbIrqStatus[EP_NUM-1:0] | ~$past(endpointEvt, 2)))
      else $error("endpoint flag missing");
   a_enable_write: assert property (
      psel && penable && pready && pwrite && pstrb == 4'hF
      && paddr == UIF_ADDR_ENABLE
      |=> usbIrqEnable == ($past(pwdata) & UIF_ENABLE_MASK))
      else $error("enable write not applied");
   a_ready_wait: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not one wait state");
endmodule
bind uif_irq_top uif_irq_top_monitor #(.EP_NUM(EP_NUM)) mon (
   .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .endpointEvt(endpointEvt), .suspendEvt(suspendEvt),
   .resumeEvt(resumeEvt), .busResetEvt(busResetEvt),
   .disconnectDoneEvt(disconnectDoneEvt), .usbIrqEnable(usbIrqEnable),
   .usbIrqStatus(usbIrqStatus), .irqReq(irqReq));
`default_nettype wire

// ### tb/uif_usb_core_model.sv
// usb core stand-in that raises one-cycle event pulses
`timescale 1ns/1ns
`default_nettype none
module uif_usb_core_model
   import uif_pkg::*;
(
   // clock
   input wire logic                 sys_clk,
   // event pulses toward the flag block
   output logic [UIF_EP_NUM-1:0]    endpointEvt,
   output logic                     suspendEvt,
   output logic                     resumeEvt,
   output logic                     busResetEvt,
   output logic                     disconnectDoneEvt
);
   logic [31:0] pulseVec_q = 32'h0000_0000;
   // pulse vector laid on the status bit positions
   assign endpointEvt       = pulseVec_q[UIF_EP_NUM-1:0];
   assign suspendEvt        = pulseVec_q[UIF_BIT_SUSPEND];
   assign resumeEvt         = pulseVec_q[UIF_BIT_RESUME];
   assign busResetEvt       = pulseVec_q[UIF_BIT_BUSRESET];
   assign disconnectDoneEvt = pulseVec_q[UIF_BIT_DISCONNECT];
   // one pulse of one cycle, launched just after a rising edge
   task automatic fire(input int b);
      @(posedge sys_clk);
      pulseVec_q <= 32'h0000_0001 << b;
      @(posedge sys_clk);
      pulseVec_q <= 32'h0000_0000;
   endtask
endmodule
`default_nettype wire

// ### tb/test_usb_device_interrupt_flags.sv
// self-checking bench of the usb irq flag block
`timescale 1ns/1ns
`default_nettype none
module test_usb_device_interrupt_flags;
   import uif_pkg::*;
   logic              sys_clk = 1'b0;
   logic              nrst = 1'b0;
   logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0]       paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
   logic [3:0]        pstrb = 4'h0;
   logic [3:0]        lanes = 4'hF;    // byte lanes of the next transfer
   logic [31:0]       prdata, usbIrqEnable, usbIrqStatus, rd;
   logic              pready, pslverr, irqReq, er;
   logic [4:0]        endpointEvt;
   logic              suspendEvt, resumeEvt, busResetEvt, disconnectDoneEvt;
   int                errCount = 0;
   int                samplesChecked = 0;
   int                bits [9] = '{0, 1, 2, 3, 4, 8, 9, 10, 11};
   uif_irq_top DUT (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .endpointEvt(endpointEvt), .suspendEvt(suspendEvt),
      .resumeEvt(resumeEvt), .busResetEvt(busResetEvt),
      .disconnectDoneEvt(disconnectDoneEvt), .usbIrqEnable(usbIrqEnable),
      .usbIrqStatus(usbIrqStatus), .irqReq(irqReq));
   uif_usb_core_model core (.sys_clk(sys_clk), .endpointEvt(endpointEvt),
      .suspendEvt(suspendEvt), .resumeEvt(resumeEvt),
      .busResetEvt(busResetEvt), .disconnectDoneEvt(disconnectDoneEvt));
   ////////////////////////////////////////////////////////////////////////
   // compare, count and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one apb transfer; held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= lanes;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 20) begin
         chk(32'h0000_0000, 32'h0000_0001);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // enables and status start cleared
   task automatic t_reset_values();
      apb(1'b0, UIF_ADDR_ENABLE, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(usbIrqEnable, 32'h0000_0000);
      apb(1'b0, UIF_ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("test reset values done");
   endtask
   // all ones written: only implemented enables stick, port shows them
   task automatic t_enable_access();
      apb(1'b1, UIF_ADDR_ENABLE, 32'hFFFF_FFFF);
      @(negedge sys_clk);
      chk(usbIrqEnable, UIF_ENABLE_MASK);
      apb(1'b0, UIF_ADDR_ENABLE, 32'h0000_0000);
      chk(rd, UIF_ENABLE_MASK);
      apb(1'b0, 32'hF00E_0020, 32'h0000_0000);
      chk({er, rd[30:0]}, 32'h8000_0000);
      $display("test enable access done");
   endtask
   // every source fires once under the given enables, then is cleared
   task automatic t_sources(input logic [31:0] en);
      apb(1'b1, UIF_ADDR_ENABLE, en);
      foreach (bits[i]) begin
         core.fire(bits[i]);
         // flag lands on the pulse edge, the request one edge later
         repeat (2) @(negedge sys_clk);
         chk(32'(irqReq), 32'(en[bits[i]]));
         apb(1'b0, UIF_ADDR_STATUS, 32'h0000_0000);
         chk(rd, 32'h0000_0001 << bits[i]);
         apb(1'b1, UIF_ADDR_STATUS, 32'h0000_0001 << bits[i]);
      end
      $display("test sources done with enables %h", en);
   endtask
   // byte lanes, pending and overrun views, then a reset in mid-run
   task automatic t_lanes_and_reset();
      lanes = 4'h2;
      apb(1'b1, UIF_ADDR_ENABLE, 32'h0000_0000);
      lanes = 4'hF;
      @(negedge sys_clk);
      chk(usbIrqEnable, 32'h0000_001F);
      core.fire(UIF_BIT_SUSPEND);
      core.fire(UIF_BIT_SUSPEND);
      core.fire(UIF_BIT_EP0);
      repeat (2) @(negedge sys_clk);
      chk(usbIrqStatus, 32'h0000_0101);
      chk(32'(irqReq), 32'h0000_0001);
      apb(1'b0, UIF_ADDR_PENDING, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      apb(1'b0, UIF_ADDR_OVERRUN, 32'h0000_0000);
      chk(rd, 32'h0000_0100);
      lanes = 4'h1;
      apb(1'b1, UIF_ADDR_STATUS, 32'h0000_0101);
      lanes = 4'hF;
      apb(1'b0, UIF_ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0100);
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      @(negedge sys_clk);
      chk(usbIrqEnable, 32'h0000_0000);
      chk(usbIrqStatus | 32'(irqReq), 32'h0000_0000);
      apb(1'b0, UIF_ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("test lanes and reset done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // clock, watchdog and main sequence
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      #1000000;
      errCount++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset_values();
      t_enable_access();
      t_sources(32'h0000_0000);
      t_sources(UIF_ENABLE_MASK);
      t_lanes_and_reset();
      summarize();
   end
endmodule
`default_nettype wire
